// >>> dsw_wake_status.sv
// Operation
// R1 - 8-bit RW register, reset sets only bit0
// R2 - bit7 sets on deep sleep fault
// R3 - bit5 sets on ulp wake event
// R4 - bit3 sets on clock alarm
// R5 - bit2 sets on master clear pin
// R6 - bits 6 and 1 read zero
// R7 - power-on flag sets anytime, others sleep-only
// R8 - bit4 sets on sleep watchdog expiry
//
// Design decision made here: the AHB-Lite register port.
`timescale 1ns/10ps
module dsw_wake_status (
  // clock and reset
  input  wire logic            hclk,
  input  wire logic            hresetn,
  // ahb-lite slave
  input  wire logic            hsel,
  input  wire logic [31:0]     haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic [31:0]     hwdata,
  input  wire logic            hready,
  output logic                 hreadyout,
  output logic                 hresp,
  output logic [31:0]          hrdata,
  // wake events, one-cycle or level, synchronous
  input  wire dsw_pkg::dsw_evt_s evt,
  // status
  output logic                 in_deep_sleep,
  output logic                 irq
);

  dsw_pkg::dsw_state_s s_q;
  dsw_pkg::dsw_state_s s_d;

  logic       addr_ok;
  logic       wr_wake;
  logic       wr_stat;
  logic [7:0] hw_set;
  logic [7:0] wdat;

  function automatic logic [31:0] rd_mux(input logic [13:0] a,
                                         input dsw_pkg::dsw_state_s s);
    rd_mux = 32'h0000_0000;
    case (a)
      dsw_pkg::WAKE_LOW_ADDR: rd_mux = {24'h00_0000, s.wake_q};
      dsw_pkg::IRQ_STAT_ADDR: rd_mux = {24'h00_0000, s.stat_q};
      dsw_pkg::IRQ_MASK_ADDR: rd_mux = {24'h00_0000, s.mask_q};
      dsw_pkg::CTRL_ADDR:     rd_mux = {31'h0000_0000, s.sleep_q};
      default:                rd_mux = 32'h0000_0000;
    endcase
  endfunction

  assign addr_ok = hsel && hready && htrans[1];
  assign wdat    = hwdata[7:0];
  assign wr_wake = s_q.ph_sel_q && s_q.ph_wr_q &&
                   (s_q.ph_addr_q == dsw_pkg::WAKE_LOW_ADDR);
  assign wr_stat = s_q.ph_sel_q && s_q.ph_wr_q &&
                   (s_q.ph_addr_q == dsw_pkg::IRQ_STAT_ADDR);

  always_comb begin
    hw_set = dsw_pkg::ZERO8;
    // R7 power-on anytime
    hw_set[dsw_pkg::POR_BIT]  = evt.power_on;
    // R2 fault in sleep
    hw_set[dsw_pkg::FLT_BIT]  = evt.sleep_fault && s_q.sleep_q;
    // R3 ulp wake
    hw_set[dsw_pkg::ULP_BIT]  = evt.ulp_wake && s_q.sleep_q;
    // R8 watchdog expiry
    hw_set[dsw_pkg::WDT_BIT]  = evt.watchdog_timeout && s_q.sleep_q;
    // R4 clock alarm
    hw_set[dsw_pkg::RTC_BIT]  = evt.clock_alarm && s_q.sleep_q;
    // R5 master clear pin
    hw_set[dsw_pkg::MASTER_CLEAR_PIN_BIT] = evt.master_clear_pin && s_q.sleep_q;
  end

  always_comb begin
    s_d = s_q;
    s_d.ph_sel_q = addr_ok;
    if (addr_ok) begin
      s_d.ph_wr_q   = hwrite;
      s_d.ph_addr_q = {haddr[13:2], 2'b00};
    end
    if (addr_ok && !hwrite) begin
      s_d.rdata_q = rd_mux({haddr[13:2], 2'b00}, s_q);
    end
    // R1 software write, then hardware set wins
    if (wr_wake) begin
      s_d.wake_q = wdat;
    end
    // R6 unimplemented bits forced to zero
    s_d.wake_q = (s_d.wake_q | hw_set) & dsw_pkg::WAKE_IMPL_MASK;
    // interrupt status: write one clears, set wins
    if (wr_stat) begin
      s_d.stat_q = s_q.stat_q & ~wdat;
    end
    s_d.stat_q = (s_d.stat_q | hw_set) & dsw_pkg::WAKE_IMPL_MASK;
    if (s_q.ph_sel_q && s_q.ph_wr_q) begin
      case (s_q.ph_addr_q)
        dsw_pkg::IRQ_MASK_ADDR:
          s_d.mask_q = wdat & dsw_pkg::WAKE_IMPL_MASK;
        dsw_pkg::CTRL_ADDR:
          s_d.sleep_q = hwdata[dsw_pkg::CTRL_SLEEP_BIT];
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // R1 reset value, power-on flag up
      s_q.wake_q    <= dsw_pkg::WAKE_RESET;
      s_q.stat_q    <= dsw_pkg::ZERO8;
      s_q.mask_q    <= dsw_pkg::ZERO8;
      s_q.sleep_q   <= 1'b0;
      s_q.ph_sel_q  <= 1'b0;
      s_q.ph_wr_q   <= 1'b0;
      s_q.ph_addr_q <= 14'h0000;
      s_q.rdata_q   <= 32'h0000_0000;
    end else begin
      s_q <= s_d;
    end
  end

  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;
  assign hrdata        = s_q.rdata_q;
  assign in_deep_sleep = s_q.sleep_q;
  assign irq           = |(s_q.stat_q & s_q.mask_q);

  // R6 unused bits never set
  a_unimpl_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    s_q.wake_q[6] == 1'b0 && s_q.wake_q[1] == 1'b0)
    else $error("unimplemented wake bit set"); // R6

  // R7 por sets at next edge
  a_por_sets: assert property (@(posedge hclk) disable iff (!hresetn)
    evt.power_on |=> s_q.wake_q[dsw_pkg::POR_BIT])
    else $error("power-on flag not set"); // R7

  // R7 fault flag stays off when awake
  a_awake_noset: assert property (@(posedge hclk) disable iff (!hresetn)
    (!s_q.sleep_q && !wr_wake && s_q.wake_q[7] == 1'b0) |=>
      s_q.wake_q[7] == 1'b0)
    else $error("fault flag set while awake"); // R7

  // R2 fault
  a_fault_sets: assert property (@(posedge hclk) disable iff (!hresetn)
    (evt.sleep_fault && s_q.sleep_q) |=> s_q.wake_q[dsw_pkg::FLT_BIT])
    else $error("fault flag not set"); // R2

  // R3 ulp
  a_ulp_sets: assert property (@(posedge hclk) disable iff (!hresetn)
    (evt.ulp_wake && s_q.sleep_q) |=> s_q.wake_q[dsw_pkg::ULP_BIT])
    else $error("ulp flag not set"); // R3

  // R8 watchdog
  a_wdt_sets: assert property (@(posedge hclk) disable iff (!hresetn)
    (evt.watchdog_timeout && s_q.sleep_q) |=>
      s_q.wake_q[dsw_pkg::WDT_BIT])
    else $error("watchdog flag not set"); // R8

  // R4 alarm
  a_rtc_sets: assert property (@(posedge hclk) disable iff (!hresetn)
    (evt.clock_alarm && s_q.sleep_q) |=> s_q.wake_q[dsw_pkg::RTC_BIT])
    else $error("alarm flag not set"); // R4

  // R5 master clear
  a_master_clear_pin_sets: assert property (@(posedge hclk) disable iff (!hresetn)
    (evt.master_clear_pin && s_q.sleep_q) |=>
      s_q.wake_q[dsw_pkg::MASTER_CLEAR_PIN_BIT])
    else $error("master clear flag not set"); // R5

  // R1 flags hold with no write and no event
  a_wake_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (!wr_wake && hw_set == dsw_pkg::ZERO8) |=>
      s_q.wake_q == $past(s_q.wake_q))
    else $error("wake register changed by itself"); // R1

  // R7 ulp stays off when awake
  a_ulp_awake: assert property (@(posedge hclk) disable iff (!hresetn) // R7
    (!s_q.sleep_q && !wr_wake && !s_q.wake_q[dsw_pkg::ULP_BIT]) |=>
      !s_q.wake_q[dsw_pkg::ULP_BIT])
    else $error("ulp flag set while awake");

  // R7 watchdog stays off when awake
  a_wdt_awake: assert property (@(posedge hclk) disable iff (!hresetn) // R7
    (!s_q.sleep_q && !wr_wake && !s_q.wake_q[dsw_pkg::WDT_BIT]) |=>
      !s_q.wake_q[dsw_pkg::WDT_BIT])
    else $error("watchdog flag set while awake");

  // R7 alarm stays off when awake
  a_rtc_awake: assert property (@(posedge hclk) disable iff (!hresetn) // R7
    (!s_q.sleep_q && !wr_wake && !s_q.wake_q[dsw_pkg::RTC_BIT]) |=>
      !s_q.wake_q[dsw_pkg::RTC_BIT])
    else $error("alarm flag set while awake");

  // R7 master clear stays off when awake
  a_master_clear_pin_awake: assert property (@(posedge hclk) disable iff (!hresetn) // R7
    (!s_q.sleep_q && !wr_wake && !s_q.wake_q[dsw_pkg::MASTER_CLEAR_PIN_BIT]) |=>
      !s_q.wake_q[dsw_pkg::MASTER_CLEAR_PIN_BIT])
    else $error("master clear flag set while awake");

  // R1 slave never stalls
  a_ready_high: assert property (@(posedge hclk) disable iff (!hresetn) // R1
    hreadyout == 1'b1)
    else $error("slave inserted a wait state");

  // R1 response always okay
  a_resp_okay: assert property (@(posedge hclk) disable iff (!hresetn) // R1
    hresp == 1'b0)
    else $error("slave gave an error response");

  // R1 plain write lands in implemented bits
  a_wake_write: assert property (@(posedge hclk) disable iff (!hresetn) // R1
    (wr_wake && hw_set == dsw_pkg::ZERO8) |=>
      s_q.wake_q == ($past(wdat) & dsw_pkg::WAKE_IMPL_MASK))
    else $error("wake write not stored");

  // R1 status write one clears
  a_stat_clear: assert property (@(posedge hclk) disable iff (!hresetn) // R1
    (wr_stat && hw_set == dsw_pkg::ZERO8) |=>
      s_q.stat_q == ($past(s_q.stat_q) & ~$past(wdat)))
    else $error("status write one clear failed");

  // R6 status unimplemented bits stay zero
  a_stat_unimpl: assert property (@(posedge hclk) disable iff (!hresetn) // R6
    (s_q.stat_q & ~dsw_pkg::WAKE_IMPL_MASK) == dsw_pkg::ZERO8)
    else $error("unimplemented status bit set");

  // R6 read data of wake register
  a_rd_unimpl: assert property (@(posedge hclk) disable iff (!hresetn) // R6
    (s_q.ph_sel_q && !s_q.ph_wr_q &&
     s_q.ph_addr_q == dsw_pkg::WAKE_LOW_ADDR) |->
      (hrdata[6] == 1'b0 && hrdata[1] == 1'b0))
    else $error("unimplemented wake bit read as one");

  // R6 upper read bits zero
  a_rd_upper: assert property (@(posedge hclk) disable iff (!hresetn) // R6
    (s_q.ph_sel_q && !s_q.ph_wr_q &&
     s_q.ph_addr_q == dsw_pkg::WAKE_LOW_ADDR) |->
      hrdata[31:8] == 24'h00_0000)
    else $error("upper wake read bits not zero");

  // R7 power-on flag sticky
  a_por_sticky: assert property (@(posedge hclk) disable iff (!hresetn) // R7
    (s_q.wake_q[dsw_pkg::POR_BIT] && !wr_wake) |=>
      s_q.wake_q[dsw_pkg::POR_BIT])
    else $error("power-on flag dropped");

  // R2 fault flag sticky
  a_flt_sticky: assert property (@(posedge hclk) disable iff (!hresetn) // R2
    (s_q.wake_q[dsw_pkg::FLT_BIT] && !wr_wake) |=>
      s_q.wake_q[dsw_pkg::FLT_BIT])
    else $error("fault flag dropped");

  // R3 ulp flag sticky
  a_ulp_sticky: assert property (@(posedge hclk) disable iff (!hresetn) // R3
    (s_q.wake_q[dsw_pkg::ULP_BIT] && !wr_wake) |=>
      s_q.wake_q[dsw_pkg::ULP_BIT])
    else $error("ulp flag dropped");

  // R8 watchdog flag sticky
  a_wdt_sticky: assert property (@(posedge hclk) disable iff (!hresetn) // R8
    (s_q.wake_q[dsw_pkg::WDT_BIT] && !wr_wake) |=>
      s_q.wake_q[dsw_pkg::WDT_BIT])
    else $error("watchdog flag dropped");

  // R4 alarm flag sticky
  a_rtc_sticky: assert property (@(posedge hclk) disable iff (!hresetn) // R4
    (s_q.wake_q[dsw_pkg::RTC_BIT] && !wr_wake) |=>
      s_q.wake_q[dsw_pkg::RTC_BIT])
    else $error("alarm flag dropped");

  // R5 master clear flag sticky
  a_master_clear_pin_sticky: assert property (@(posedge hclk) disable iff (!hresetn) // R5
    (s_q.wake_q[dsw_pkg::MASTER_CLEAR_PIN_BIT] && !wr_wake) |=>
      s_q.wake_q[dsw_pkg::MASTER_CLEAR_PIN_BIT])
    else $error("master clear flag dropped");

  // R1 mask keeps implemented bits only
  a_mask_unimpl: assert property (@(posedge hclk) disable iff (!hresetn) // R1
    (s_q.mask_q & ~dsw_pkg::WAKE_IMPL_MASK) == dsw_pkg::ZERO8)
    else $error("unimplemented mask bit set");

  // R7 status follows power-on event
  a_stat_por: assert property (@(posedge hclk) disable iff (!hresetn) // R7
    evt.power_on |=> s_q.stat_q[dsw_pkg::POR_BIT])
    else $error("power-on status not set");

  // R1 read data stays put without a new read
  a_rdata_hold: assert property (@(posedge hclk) disable iff (!hresetn) // R1
    !(addr_ok && !hwrite) |=> hrdata == $past(hrdata))
    else $error("read data changed without a read");

endmodule

// >>> dsw_pkg.sv
package dsw_pkg;
  // register map (printed offset 0xf4a is not a multiple of four: index)
  localparam logic [11:0] WAKE_LOW_IDX  = 12'h0f4a;
  localparam logic [13:0] WAKE_LOW_ADDR = {WAKE_LOW_IDX, 2'b00};
  localparam logic [13:0] IRQ_STAT_ADDR = 14'h3d40;
  localparam logic [13:0] IRQ_MASK_ADDR = 14'h3d44;
  localparam logic [13:0] CTRL_ADDR     = 14'h3d48;
  // field positions
  localparam int FLT_BIT  = 7;
  localparam int ULP_BIT  = 5;
  localparam int WDT_BIT  = 4;
  localparam int RTC_BIT  = 3;
  localparam int MASTER_CLEAR_PIN_BIT = 2;
  localparam int POR_BIT  = 0;
  localparam int CTRL_SLEEP_BIT = 0;
  // implemented bits and reset value
  localparam logic [7:0] WAKE_IMPL_MASK = 8'hbd;
  localparam logic [7:0] WAKE_RESET     = 8'h01;
  localparam logic [7:0] ZERO8          = 8'h00;

  typedef struct packed {
    logic       sleep_fault;
    logic       ulp_wake;
    logic       watchdog_timeout;
    logic       clock_alarm;
    logic       master_clear_pin;
    logic       power_on;
  } dsw_evt_s;

  typedef struct packed {
    logic [7:0]  wake_q;
    logic [7:0]  stat_q;
    logic [7:0]  mask_q;
    logic        sleep_q;
    logic        ph_sel_q;
    logic        ph_wr_q;
    logic [13:0] ph_addr_q;
    logic [31:0] rdata_q;
  } dsw_state_s;
endpackage

// >>> dsw_testbench.sv
`timescale 1ns/10ps
module testbench;
  logic              hclk = 1'b0;
  logic              hresetn = 1'b0;
  logic              hsel = 1'b0;
  logic              hwrite = 1'b0;
  logic [1:0]        htrans = 2'h0;
  logic [2:0]        hsize = 3'h2;
  logic [31:0]       haddr = 32'h0000_0000;
  logic [31:0]       hwdata = 32'h0000_0000;
  logic [31:0]       hrdata;
  logic [31:0]       rd;
  logic              hreadyout;
  logic              hresp;
  logic              in_deep_sleep;
  logic              irq;
  dsw_pkg::dsw_evt_s evt = '0;
  int                err_count = 0;
  int                num_checks = 0;
  int                cyc = 0;
  // expected flag per event, in struct order msb first
  localparam logic [7:0] BITS [6] = '{8'h80, 8'h20, 8'h10, 8'h08, 8'h04, 8'h01};
  always #12.5 hclk = ~hclk;
  // single slave: its hreadyout is the bus hready
  dsw_wake_status dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .evt(evt),
    .in_deep_sleep(in_deep_sleep), .irq(irq));
  task automatic bus(input logic w, input logic [13:0] a, input logic [7:0] d);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {18'h0_0000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= {24'h00_0000, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic pulse(input logic [5:0] e);
    evt <= e;
    @(posedge hclk);
    evt <= '0;
    @(posedge hclk);
  endtask
  task automatic t_reset();
    bus(1'b0, dsw_pkg::WAKE_LOW_ADDR, 8'h00);
    chk("wake reset", rd, 32'h0000_0001);
    chk("hresp", {31'h0, hresp}, 32'h0000_0000);
  endtask
  task automatic t_awake();
    bus(1'b1, dsw_pkg::WAKE_LOW_ADDR, 8'h00);
    pulse(6'h3f);
    bus(1'b0, dsw_pkg::WAKE_LOW_ADDR, 8'h00);
    chk("wake awake", rd, 32'h0000_0001);
  endtask
  task automatic t_sleep();
    bus(1'b1, dsw_pkg::CTRL_ADDR, 8'h01);
    @(posedge hclk);
    chk("sleep", {31'h0, in_deep_sleep}, 32'h0000_0001);
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, dsw_pkg::WAKE_LOW_ADDR, 8'h00);
      pulse(6'h20 >> i);
      bus(1'b0, dsw_pkg::WAKE_LOW_ADDR, 8'h00);
      chk("wake event", rd, {24'h00_0000, BITS[i]});
    end
  endtask
  task automatic t_rw();
    bus(1'b1, dsw_pkg::WAKE_LOW_ADDR, 8'hff);
    bus(1'b0, dsw_pkg::WAKE_LOW_ADDR, 8'h00);
    chk("wake rw", rd, 32'h0000_00bd);
    bus(1'b0, 14'h0100, 8'h00);
    chk("unmapped", rd, 32'h0000_0000);
  endtask
  task automatic t_irq();
    bus(1'b1, dsw_pkg::IRQ_STAT_ADDR, 8'hff);
    bus(1'b1, dsw_pkg::IRQ_MASK_ADDR, 8'h04);
    pulse(6'h02);
    chk("irq set", {31'h0, irq}, 32'h0000_0001);
    bus(1'b0, dsw_pkg::IRQ_STAT_ADDR, 8'h00);
    chk("stat", rd, 32'h0000_0004);
    bus(1'b1, dsw_pkg::IRQ_MASK_ADDR, 8'h00);
    @(posedge hclk);
    chk("irq masked", {31'h0, irq}, 32'h0000_0000);
    bus(1'b1, dsw_pkg::IRQ_MASK_ADDR, 8'h04);
    bus(1'b1, dsw_pkg::IRQ_STAT_ADDR, 8'h04);
    @(posedge hclk);
    chk("irq clear", {31'h0, irq}, 32'h0000_0000);
    bus(1'b0, dsw_pkg::IRQ_STAT_ADDR, 8'h00);
    chk("stat clear", rd, 32'h0000_0000);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ceiling well above the roughly 80 cycles the tests need
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_awake();
    t_sleep();
    t_rw();
    t_irq();
    give_verdict();
  end
endmodule
